// ===== dmacc_top.sv
`timescale 1ns/1ps
`include "dmacc_map.svh"
module dmacc_top
   import dmacc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Channel events
   input  wire logic [3:0]  start_evt_i,
   input  wire logic [3:0]  abort_evt_i,
   // Data mover side
   output logic             xfer_req_o,
   output logic      [1:0]  xfer_ch_o,
   input  wire logic        xfer_ack_i,
   input  wire logic        xfer_addr_err_i,
   input  wire logic        xfer_pattern_i,
   // Interrupt
   output logic             irq_o
);

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   ////////////////////////////////////////////////////////////////////////
   // State and helpers

   dmacc_cfg_t  cfg  [`DMACC_NCH];
   logic [4:0]  flg  [`DMACC_NCH];
   logic [4:0]  ien  [`DMACC_NCH];
   logic [15:0] ssz  [`DMACC_NCH];
   logic [15:0] dsz  [`DMACC_NCH];
   logic [15:0] csz  [`DMACC_NCH];
   logic [16:0] bcnt [`DMACC_NCH];
   logic [16:0] ccnt [`DMACC_NCH];
   logic [3:0]  edet;
   logic        suspend;
   dmacc_eng_t  state;
   logic [1:0]  cur;
   dmacc_gnt_t  gnt;
   logic [7:0]  pri_vec;
   logic        wb_req;
   logic        wr_ctl;
   logic [3:0]  wr_con;
   logic [3:0]  wr_int;
   logic [3:0]  wr_ssz;
   logic [3:0]  wr_dsz;
   logic [3:0]  wr_csz;
   logic [3:0]  req;
   logic [3:0]  busy;
   logic [3:0]  ack_here;
   logic [3:0]  err_ev;
   logic [3:0]  blk_ev;
   logic [3:0]  half_ev;
   logic [3:0]  cell_ev;
   logic [3:0]  abt_ev;
   logic [3:0]  st_ev;
   logic [3:0]  chain_ev;

   // Zero encodes the full 64 KiB count
   function automatic logic [16:0] size17(input logic [15:0] v);
      return (v == `DMACC_RST_SIZE) ? `DMACC_FULL_SIZE : {1'b0, v};
   endfunction

   function automatic logic [16:0] max17(input logic [16:0] a,
                                         input logic [16:0] b);
      return (a > b) ? a : b;
   endfunction

   // Byte-lane merge of a write into an old word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] con_word(input dmacc_cfg_t c,
                                            input logic       b,
                                            input logic       e);
      logic [31:0] w;
      w = `DMACC_RST_WORD;
      w[`DMACC_BUSY_BIT] = b;
      w[`DMACC_CHNS_BIT] = c.chns;
      w[`DMACC_EN_BIT]   = c.en;
      w[`DMACC_AED_BIT]  = c.aed;
      w[`DMACC_CHN_BIT]  = c.chn;
      w[`DMACC_AEN_BIT]  = c.aen;
      w[`DMACC_EDET_BIT] = e;
      w[`DMACC_PRI_LSB +: 2] = c.pri;
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bus decode

   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_ctl = wb_req & wb_we_i & (wb_adr_i == `DMACC_CTL_ADDR);

   // Per-channel write strobes
   always_comb begin
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < `DMACC_NCH; i++) begin
         hit = wb_req & wb_we_i & ~wb_adr_i[7] &
               (wb_adr_i[6:5] == 2'(i));
         wr_con[i] = hit & (wb_adr_i[4:2] == `DMACC_CON_IDX);
         wr_int[i] = hit & (wb_adr_i[4:2] == `DMACC_INT_IDX);
         wr_ssz[i] = hit & (wb_adr_i[4:2] == `DMACC_SSZ_IDX);
         wr_dsz[i] = hit & (wb_adr_i[4:2] == `DMACC_DSZ_IDX);
         wr_csz[i] = hit & (wb_adr_i[4:2] == `DMACC_CSZ_IDX);
      end
   end

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   // Registered read data, unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= `DMACC_RST_WORD;
      end else if (wb_req && !wb_we_i) begin
         wb_dat_o <= `DMACC_RST_WORD;
         if (wb_adr_i == `DMACC_CTL_ADDR) begin
            wb_dat_o[`DMACC_SUSP_BIT]  <= suspend;
            wb_dat_o[`DMACC_GBUSY_BIT] <= |busy;
         end else if (!wb_adr_i[7]) begin
            case (wb_adr_i[4:2])
               `DMACC_CON_IDX: wb_dat_o <= con_word(cfg[wb_adr_i[6:5]],
                  busy[wb_adr_i[6:5]], edet[wb_adr_i[6:5]]);
               `DMACC_INT_IDX: wb_dat_o <= {11'h0, ien[wb_adr_i[6:5]],
                                            11'h0, flg[wb_adr_i[6:5]]};
               `DMACC_SSZ_IDX: wb_dat_o <= {16'h0, ssz[wb_adr_i[6:5]]};
               `DMACC_DSZ_IDX: wb_dat_o <= {16'h0, dsz[wb_adr_i[6:5]]};
               `DMACC_CSZ_IDX: wb_dat_o <= {16'h0, csz[wb_adr_i[6:5]]};
               default:        wb_dat_o <= `DMACC_RST_WORD;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel events

   always_comb begin
      logic [16:0] nb;
      nb = '0;
      for (int i = 0; i < `DMACC_NCH; i++) begin
         nb = bcnt[i] + 17'h1;
         ack_here[i] = (state == ENG_XFER) && (cur == 2'(i)) && xfer_ack_i;
         err_ev[i]   = ack_here[i] & xfer_addr_err_i;
         blk_ev[i]   = ack_here[i] & ~xfer_addr_err_i & (xfer_pattern_i |
                       (nb == max17(size17(ssz[i]), size17(dsz[i]))));
         half_ev[i]  = ack_here[i] & ~xfer_addr_err_i &
                       (nb == (size17(dsz[i]) >> 1));
         cell_ev[i]  = ack_here[i] & ~xfer_addr_err_i &
                       ((ccnt[i] + 17'h1) == size17(csz[i]));
         abt_ev[i]   = abort_evt_i[i] & (cfg[i].en | cfg[i].aed);
         st_ev[i]    = start_evt_i[i] & (cfg[i].en | cfg[i].aed);
         busy[i]     = cfg[i].en | ((state == ENG_XFER) && (cur == 2'(i)));
         req[i]      = cfg[i].en & edet[i] & ~suspend;
         pri_vec[2*i +: 2] = cfg[i].pri;
      end
      // Completion of a neighbour, steered by the direction bit
      for (int i = 0; i < `DMACC_NCH; i++) begin
         chain_ev[i] = 1'b0;
         if (cfg[i].chn) begin
            if (cfg[i].chns) begin
               chain_ev[i] = (i < `DMACC_NCH - 1) ? blk_ev[(i + 1) % 4]
                                                  : 1'b0;
            end else begin
               chain_ev[i] = (i > 0) ? blk_ev[(i + 3) % 4] : 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel configuration and enable

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < `DMACC_NCH; i++) begin
            cfg[i] <= '0;
         end
      end else begin
         for (int i = 0; i < `DMACC_NCH; i++) begin
            logic [31:0] m;
            m = merge(con_word(cfg[i], busy[i], edet[i]), wb_dat_i, wb_sel_i);
            if (wr_con[i]) begin
               cfg[i].chns <= m[`DMACC_CHNS_BIT];
               cfg[i].en   <= m[`DMACC_EN_BIT];
               cfg[i].aed  <= m[`DMACC_AED_BIT];
               cfg[i].chn  <= m[`DMACC_CHN_BIT];
               cfg[i].aen  <= m[`DMACC_AEN_BIT];
               cfg[i].pri  <= m[`DMACC_PRI_LSB +: 2];
            end
            if (chain_ev[i]) begin
               cfg[i].en <= 1'b1;
            end
            if ((blk_ev[i] && !cfg[i].aen) || err_ev[i]) begin
               cfg[i].en <= 1'b0;
            end
         end
      end
   end

   // Event detected: start sets, completion, abort or error clears
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         edet <= 4'h0;
      end else begin
         edet <= (edet & ~(blk_ev | abt_ev | err_ev)) |
                 (st_ev & ~abt_ev);
      end
   end

   // Size registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < `DMACC_NCH; i++) begin
            ssz[i] <= `DMACC_RST_SIZE;
            dsz[i] <= `DMACC_RST_SIZE;
            csz[i] <= `DMACC_RST_SIZE;
         end
      end else begin
         for (int i = 0; i < `DMACC_NCH; i++) begin
            if (wr_ssz[i]) begin
               ssz[i] <= 16'(merge({16'h0, ssz[i]}, wb_dat_i, wb_sel_i));
            end
            if (wr_dsz[i]) begin
               dsz[i] <= 16'(merge({16'h0, dsz[i]}, wb_dat_i, wb_sel_i));
            end
            if (wr_csz[i]) begin
               csz[i] <= 16'(merge({16'h0, csz[i]}, wb_dat_i, wb_sel_i));
            end
         end
      end
   end

   // Byte and cell counters
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < `DMACC_NCH; i++) begin
            bcnt[i] <= '0;
            ccnt[i] <= '0;
         end
      end else begin
         for (int i = 0; i < `DMACC_NCH; i++) begin
            if (blk_ev[i] || abt_ev[i] || err_ev[i]) begin
               bcnt[i] <= '0;
               ccnt[i] <= '0;
            end else if (ack_here[i]) begin
               bcnt[i] <= bcnt[i] + 17'h1;
               ccnt[i] <= cell_ev[i] ? 17'h0 : ccnt[i] + 17'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt flags, enables and module control

   // Hardware set wins over a write-one clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < `DMACC_NCH; i++) begin
            flg[i] <= '0;
            ien[i] <= '0;
         end
      end else begin
         for (int i = 0; i < `DMACC_NCH; i++) begin
            logic [4:0] clr;
            logic [4:0] set;
            logic [31:0] m;
            clr = wr_int[i] ? (wb_dat_i[4:0] & {5{wb_sel_i[0]}}) : 5'h0;
            set = 5'h0;
            set[`DMACC_DHIF_BIT] = half_ev[i];
            set[`DMACC_BCIF_BIT] = blk_ev[i];
            set[`DMACC_CCIF_BIT] = cell_ev[i];
            set[`DMACC_TAIF_BIT] = abt_ev[i];
            set[`DMACC_ERIF_BIT] = err_ev[i];
            flg[i] <= (flg[i] & ~clr) | set;
            m = merge({11'h0, ien[i], 16'h0}, wb_dat_i, wb_sel_i);
            if (wr_int[i]) begin
               ien[i] <= m[`DMACC_IEN_LSB +: 5];
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         suspend <= 1'b0;
      end else if (wr_ctl && wb_sel_i[1]) begin
         suspend <= wb_dat_i[`DMACC_SUSP_BIT];
      end
   end

   // Level interrupt from any enabled flag
   always_comb begin
      irq_o = 1'b0;
      for (int i = 0; i < `DMACC_NCH; i++) begin
         irq_o = irq_o | (|(flg[i] & ien[i]));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transfer engine

   dmacc_arb u_arb (
      .req_i (req),
      .pri_i (pri_vec),
      .gnt_o (gnt)
   );

   // One byte per grant; an open transaction always runs to its ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ENG_IDLE;
         cur   <= 2'h0;
      end else begin
         case (state)
            ENG_IDLE: begin
               if (gnt.valid) begin
                  state <= ENG_XFER;
                  cur   <= gnt.ch;
               end
            end
            ENG_XFER: begin
               if (xfer_ack_i) begin
                  state <= ENG_IDLE;
               end
            end
            default: state <= ENG_IDLE;
         endcase
      end
   end

   assign xfer_req_o = (state == ENG_XFER);
   assign xfer_ch_o  = cur;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   chk_busy_enabled: assert property (cfg[0].en |-> busy[0])
      else $error("busy low while enabled");
   chk_chain_dir: assert property (cfg[1].chn && cfg[1].chns && blk_ev[2]
      |=> cfg[1].en)
      else $error("chain from upper neighbour missed");
   chk_chain_gate: assert property (!cfg[1].chn && !cfg[1].en &&
      !wr_con[1] |=> !cfg[1].en)
      else $error("channel enabled without chain enable");
   chk_write_enable: assert property (wr_con[2] && wb_sel_i[0] &&
      !chain_ev[2] && !blk_ev[2] && !err_ev[2]
      |=> cfg[2].en == $past(wb_dat_i[`DMACC_EN_BIT]))
      else $error("enable write not taken");
   chk_ignore_off: assert property (!cfg[0].en && !cfg[0].aed && !edet[0]
      |=> !edet[0])
      else $error("event taken while disabled");
   chk_auto_clear: assert property (blk_ev[0] && !cfg[0].aen &&
      !wr_con[0] |=> !cfg[0].en)
      else $error("enable kept without auto enable");
   chk_event_seen: assert property (st_ev[3] && !abt_ev[3] |=> edet[3])
      else $error("start event not recorded");
   chk_prio_order: assert property (req[0] && req[1] &&
      cfg[1].pri > cfg[0].pri |-> gnt.valid && gnt.ch != 2'h0)
      else $error("lower priority granted");
   chk_finish_open: assert property (state == ENG_XFER && !xfer_ack_i
      |=> state == ENG_XFER && $stable(cur))
      else $error("transaction dropped before ack");
   chk_half_flag: assert property (half_ev[0] |=> flg[0][`DMACC_DHIF_BIT])
      else $error("half flag not set");
   chk_block_flag: assert property (blk_ev[1] |=> flg[1][`DMACC_BCIF_BIT]
      ##1 (flg[1][`DMACC_BCIF_BIT] || $past(wr_int[1])))
      else $error("block flag lost");
   chk_cell_flag: assert property (cell_ev[0] |=> flg[0][`DMACC_CCIF_BIT]
      && ccnt[0] == 17'h0)
      else $error("cell completion wrong");
   chk_abort_flag: assert property (abt_ev[2] |=> flg[2][`DMACC_TAIF_BIT]
      && !edet[2] && bcnt[2] == 17'h0)
      else $error("abort not handled");
   chk_addr_error: assert property (err_ev[3] |=> flg[3][`DMACC_ERIF_BIT]
      && !cfg[3].en)
      else $error("address error not flagged");
   chk_full_size: assert property (ssz[1] == 16'h0 && dsz[1] == 16'h0 &&
      ack_here[1] && !xfer_addr_err_i |-> blk_ev[1] == (bcnt[1] ==
      17'hffff || xfer_pattern_i))
      else $error("zero size not 65536");
   chk_suspend_hold: assert property (suspend && state == ENG_IDLE
      |=> state == ENG_IDLE)
      else $error("transfer started while suspended");

endmodule

// ===== dmacc_map.svh
`ifndef DMACC_MAP_SVH
`define DMACC_MAP_SVH

// Channel count and register window
`define DMACC_NCH          4
`define DMACC_CH_NUM_W     2
`define DMACC_CTL_ADDR     8'h80

// Word index of each register inside one channel window
`define DMACC_CON_IDX      3'h0
`define DMACC_INT_IDX      3'h1
`define DMACC_SSZ_IDX      3'h2
`define DMACC_DSZ_IDX      3'h3
`define DMACC_CSZ_IDX      3'h4

// Channel control fields
`define DMACC_BUSY_BIT     15
`define DMACC_CHNS_BIT     8
`define DMACC_EN_BIT       7
`define DMACC_AED_BIT      6
`define DMACC_CHN_BIT      5
`define DMACC_AEN_BIT      4
`define DMACC_EDET_BIT     2
`define DMACC_PRI_LSB      0

// Interrupt control fields
`define DMACC_DHIF_BIT     4
`define DMACC_BCIF_BIT     3
`define DMACC_CCIF_BIT     2
`define DMACC_TAIF_BIT     1
`define DMACC_ERIF_BIT     0
`define DMACC_IEN_LSB      16

// Module control fields
`define DMACC_SUSP_BIT     12
`define DMACC_GBUSY_BIT    11

// Reset values and size encoding
`define DMACC_RST_WORD     32'h0000_0000
`define DMACC_RST_SIZE     16'h0000
`define DMACC_FULL_SIZE    17'h1_0000

`endif

// ===== dmacc_pkg.sv
package dmacc_pkg;

   // Software-written channel configuration
   typedef struct packed {
      logic       chns;
      logic       en;
      logic       aed;
      logic       chn;
      logic       aen;
      logic [1:0] pri;
   } dmacc_cfg_t;

   // Arbiter result
   typedef struct packed {
      logic       valid;
      logic [1:0] ch;
   } dmacc_gnt_t;

   // Transfer engine states
   typedef enum logic [0:0] {
      ENG_IDLE = 1'b0,
      ENG_XFER = 1'b1
   } dmacc_eng_t;

endpackage

// ===== dmacc_arb.sv
`timescale 1ns/1ps
`include "dmacc_map.svh"
module dmacc_arb
   import dmacc_pkg::*;
(
   // Requests and programmed priorities
   input  wire logic [3:0] req_i,
   input  wire logic [7:0] pri_i,
   // Winner
   output dmacc_gnt_t      gnt_o
);

   // Highest level wins, lower channel number breaks ties
   always_comb begin
      gnt_o = '0;
      for (int i = 0; i < `DMACC_NCH; i++) begin
         if (req_i[i] && (!gnt_o.valid ||
             pri_i[2*i +: 2] > pri_i[2*gnt_o.ch +: 2])) begin
            gnt_o.valid = 1'b1;
            gnt_o.ch    = 2'(i);
         end
      end
   end

endmodule

// ===== dmacc_mover_model.sv
`timescale 1ns/1ps
module dmacc_mover_model (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Engine request and behaviour knobs
   input  wire logic       req_i,
   input  wire logic [3:0] wait_i,
   input  wire logic       err_i,
   input  wire logic       pat_i,
   // Answer to the engine
   output logic            ack_o,
   output logic            err_o,
   output logic            pat_o
);
   logic [3:0] cnt;

   // Move one byte after wait_i cycles, qualifiers valid only with ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         err_o <= 1'b1;
         pat_o <= 1'b1;
         cnt   <= 4'h0;
      end else if (ack_o) begin
         ack_o <= 1'b0;                  // Open move ends here
         err_o <= ~err_o;                // Stale qualifiers keep moving
         pat_o <= ~pat_o;
      end else if (req_i && cnt >= wait_i) begin
         ack_o <= 1'b1;                  // Finish the open move
         err_o <= err_i;
         pat_o <= pat_i;
         cnt   <= 4'h0;
      end else begin
         cnt   <= req_i ? cnt + 4'h1 : 4'h0;
         err_o <= ~err_o;
         pat_o <= ~pat_o;
      end
   end
endmodule

// ===== dma_channel_control_tb_top.sv
`timescale 1ns/1ps
module dma_channel_control_tb_top;
   logic        clk_i = 1'b0, rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hf, start_evt_i = 4'h0, abort_evt_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
   logic        wb_ack_o, xfer_req_o, xfer_ack_i, err_q, pat_q, irq_o;
   logic [1:0]  xfer_ch_o;
   logic [3:0]  wait_n = 4'h0;
   logic        err_n = 1'b0, pat_n = 1'b0;
   int          seed = 64586, mismatches = 0, n_compared = 0;
   int          nbytes = 0, cyc_n = 0, nb, s, d, c, ch, p0, p1, w, e;

   dmacc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .start_evt_i(start_evt_i),
      .abort_evt_i(abort_evt_i), .xfer_req_o(xfer_req_o),
      .xfer_ch_o(xfer_ch_o), .xfer_ack_i(xfer_ack_i),
      .xfer_addr_err_i(err_q), .xfer_pattern_i(pat_q), .irq_o(irq_o));

   dmacc_mover_model mover (.clk_i(clk_i), .rst_i(rst_i),
      .req_i(xfer_req_o), .wait_i(wait_n), .err_i(err_n), .pat_i(pat_n),
      .ack_o(xfer_ack_i), .err_o(err_q), .pat_o(pat_q));

   // Clock
   initial begin
      forever #2 clk_i = ~clk_i;
   end

   // Byte counter and hang guard
   always @(posedge clk_i) begin
      if (xfer_req_o === 1'b1 && xfer_ack_i === 1'b1) nbytes <= nbytes + 1;
      cyc_n++;
      if (cyc_n == 20000) begin
         mismatches++;
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Classic single cycle, held until ack
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] dat);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= dat;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      wb(1'b1, a, dat);
   endtask

   task automatic rd(input logic [7:0] a);
      wb(1'b0, a, 32'h0);
   endtask

   task automatic go(input logic [3:0] m);
      start_evt_i <= m;
      @(posedge clk_i);
      start_evt_i <= 4'h0;
   endtask

   // Wait until the mover has been quiet for eight cycles
   task automatic idle();
      int k;
      k = 0;
      while (k < 8) begin
         @(posedge clk_i);
         k = (xfer_req_o === 1'b0) ? k + 1 : 0;
      end
   endtask

   task automatic wait_req();
      while (xfer_req_o !== 1'b1) @(posedge clk_i);
   endtask

   // Flags after a clean block: half, block, cell
   function automatic logic [31:0] exp_int(int s, int d, int c);
      int m;
      m = (s > d) ? s : d;
      exp_int = {16'h001f, 11'h0, d > 1, 1'b1, c <= m, 2'b00};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 4; i++)
         for (int o = 0; o < 20; o += 4) begin
            rd(8'(i * 32 + o));
            chk(rdat, 32'h0);
         end
      wr(8'h18, 32'hffff_ffff);
      rd(8'h18);
      chk(rdat, 32'h0);
      wr(8'h28, 32'hffff_0000);
      rd(8'h28);
      chk(rdat, 32'h0);
      wr(8'h20, 32'hffff_ff7f);
      rd(8'h20);
      chk(rdat, 32'h0000_0173);
      wr(8'h20, 32'h0);
      // Random blocks with clean completion
      for (int i = 0; i < 4; i++) begin
         ch = $random(seed) & 3;
         s = 1 + ($random(seed) & 15);
         d = 1 + ($random(seed) & 15);
         c = 1 + ($random(seed) & 3);
         wait_n <= 4'($random(seed) & 3);
         wr(8'(ch * 32 + 8), 32'(s));
         wr(8'(ch * 32 + 12), 32'(d));
         wr(8'(ch * 32 + 16), 32'(c));
         wr(8'(ch * 32 + 4), 32'h001f_001f);
         wr(8'(ch * 32), 32'h80);
         rd(8'(ch * 32));
         chk(rdat, 32'h8080);
         nb = nbytes;
         go(4'(1 << ch));
         idle();
         chk(32'(nbytes - nb), 32'((s > d) ? s : d));
         rd(8'(ch * 32 + 4));
         chk(rdat, exp_int(s, d, c));
         chk({31'h0, irq_o}, 32'h1);
         rd(8'(ch * 32));
         chk(rdat, 32'h0);
         wr(8'(ch * 32 + 4), 32'h0);
         chk({31'h0, irq_o}, 32'h0);
         wr(8'(ch * 32 + 4), 32'h001f_001f);
         rd(8'(ch * 32 + 4));
         chk(rdat, 32'h001f_0000);
      end
      // Short blocks on channels 0 to 2, one-byte cells
      for (int i = 0; i < 3; i++) begin
         wr(8'(i * 32 + 8), 32'd2);
         wr(8'(i * 32 + 12), 32'd2);
         wr(8'(i * 32 + 16), 32'd1);
      end
      // Auto enable keeps the channel on
      wr(8'h00, 32'h90);
      go(4'h1);
      idle();
      rd(8'h00);
      chk(rdat & 32'h90, 32'h90);
      // Chain enable and direction on channel 1
      // Bit 2 of k picks the neighbour that completes: channel 0 or 2
      for (int k = 0; k < 8; k++) begin
         e = k[0] & (k[1] == k[2]);
         wr(8'h20, {23'h0, k[1], 2'b0, k[0], 5'h0});
         wr(k[2] ? 8'h40 : 8'h00, 32'h80);
         go(k[2] ? 4'h4 : 4'h1);
         idle();
         rd(8'h20);
         w = {16'h0, e[0], 6'h0, k[1], e[0], 1'b0, k[0], 5'h0};
         chk(rdat, 32'(w));
         wr(8'h20, 32'h0);
      end
      // Suspend, then priority decides the first grant
      for (int i = 0; i < 4; i++) begin
         p0 = (i == 0) ? 2 : $random(seed) & 3;
         p1 = (i == 0) ? 2 : $random(seed) & 3;
         w = (p1 > p0) ? 1 : 0;
         wr(8'h80, 32'h1000);
         wr(8'h00, 32'(32'h80 | p0));
         wr(8'h20, 32'(32'h80 | p1));
         go(4'h3);
         repeat (10) @(posedge clk_i);
         chk({31'h0, xfer_req_o}, 32'h0);
         wr(8'h80, 32'h0);
         wait_req();
         chk({30'h0, xfer_ch_o}, 32'(w));
         idle();
      end
      // Disable mid transfer, then abort
      wait_n <= 4'd12;
      wr(8'h48, 32'd15);
      wr(8'h4c, 32'd15);
      wr(8'h50, 32'h0);
      wr(8'h44, 32'h001f_001f);
      wr(8'h40, 32'h80);
      go(4'h4);
      wait_req();
      nb = nbytes;
      wr(8'h40, 32'h0);
      idle();
      chk(32'(nbytes - nb), 32'h1);
      rd(8'h40);
      chk(rdat & 32'h8080, 32'h0);
      wr(8'h40, 32'h80);
      go(4'h4);
      wait_req();
      abort_evt_i <= 4'h4;
      @(posedge clk_i);
      abort_evt_i <= 4'h0;
      idle();
      rd(8'h44);
      chk(rdat, 32'h001f_0002);
      wr(8'h44, 32'h0000_001f);
      // Events while disabled, then address error
      wait_n <= 4'h0;
      go(4'h8);
      rd(8'h60);
      chk(rdat, 32'h0);
      wr(8'h60, 32'h40);
      go(4'h8);
      rd(8'h60);
      chk(rdat, 32'h44);
      wr(8'h68, 32'd4);
      wr(8'h6c, 32'd4);
      wr(8'h70, 32'h0);
      wr(8'h64, 32'h001f_001f);
      err_n <= 1'b1;
      nb = nbytes;
      wr(8'h60, 32'hc0);
      idle();
      err_n <= 1'b0;
      chk(32'(nbytes - nb), 32'h1);
      rd(8'h64);
      chk(rdat, 32'h001f_0001);
      rd(8'h60);
      chk(rdat, 32'h40);
      // Zero sizes run long until a pattern match ends the block
      wr(8'h28, 32'h0);
      wr(8'h2c, 32'h0);
      wr(8'h30, 32'h0);
      wr(8'h24, 32'h001f_001f);
      wr(8'h20, 32'h80);
      nb = nbytes;
      go(4'h2);
      while (nbytes < nb + 2) @(posedge clk_i);
      pat_n <= 1'b1;
      idle();
      pat_n <= 1'b0;
      chk(32'(nbytes - nb), 32'h3);
      rd(8'h24);
      chk(rdat, 32'h001f_0008);
      complete_run();
   end
endmodule
